// File: src/cbp_regs.svh
// constants for the cpu bus register port, both ends
// assumes inclusion by bare name from every file except the package
`ifndef CBP_REGS_SVH
`define CBP_REGS_SVH

// -----------------------------------------------------------------
// bus widths
// -----------------------------------------------------------------
`define CBP_ADDR_W        5
`define CBP_DATA_W        8
`define CBP_REG_COUNT     32

// -----------------------------------------------------------------
// reset and idle levels
// -----------------------------------------------------------------
`define CBP_DATA_IDLE     8'hFF
`define CBP_LINE_HIGH     1'b1
`define CBP_LINE_LOW      1'b0
`define CBP_REG_RESET     8'h00

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define CBP_CLK_PERIOD_PS 4000
// least high time of select / acknowledge-request, in clock periods
`define CBP_GAP_TCLK      2
`define CBP_GAP_CLKS      2'h2

`endif

// File: src/cbp_pkg.sv
// types shared by both ends of the cpu bus register port
// assumes the constants header is compiled alongside
package cbp_pkg;

    // -------------------------------------------------------------
    // device end sequencer
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        CBP_DEV_IDLE,
        CBP_DEV_PRESENT,
        CBP_DEV_ACK,
        CBP_DEV_DEASSERT,
        CBP_DEV_RELEASE
    } cbp_dev_state_e;

    // -------------------------------------------------------------
    // master end sequencer
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        CBP_HST_IDLE,
        CBP_HST_SETUP,
        CBP_HST_STROBE,
        CBP_HST_END,
        CBP_HST_GAP
    } cbp_hst_state_e;

    typedef enum logic [1:0] {
        CBP_CYC_READ,
        CBP_CYC_WRITE,
        CBP_CYC_INT_ACK_REQUEST_N
    } cbp_cycle_e;

endpackage

// File: src/cbp_if.sv
// pins between the bus master and the register port device
// assumes one clock for both ends; resolves shared lines from enables
`timescale 1ns/1ps
`include "cbp_regs.svh"

interface cbp_if;
    // master driven
    logic                    cs_n;
    logic                    data_strobe_n;
    logic                    rw;
    logic                    int_ack_request_n;
    logic [`CBP_ADDR_W-1:0]  register_select;
    logic [`CBP_DATA_W-1:0]  host_wdata;
    logic                    host_wdata_oe;
    // device driven
    logic [`CBP_DATA_W-1:0]  dev_rdata;
    logic                    dev_rdata_oe;
    logic                    transfer_ack_n;
    logic                    transfer_ack_oe;
    // resolved lines; pull-up when nobody drives
    logic [`CBP_DATA_W-1:0]  host_data_bus;
    logic                    ack_line_n;

    assign host_data_bus = dev_rdata_oe  ? dev_rdata :
                           host_wdata_oe ? host_wdata : `CBP_DATA_IDLE;
    assign ack_line_n    = transfer_ack_oe ? transfer_ack_n : `CBP_LINE_HIGH;

    modport dev (
        input  cs_n,
        input  data_strobe_n,
        input  rw,
        input  int_ack_request_n,
        input  register_select,
        input  host_data_bus,
        output dev_rdata,
        output dev_rdata_oe,
        output transfer_ack_n,
        output transfer_ack_oe
    );

    modport host (
        output cs_n,
        output data_strobe_n,
        output rw,
        output int_ack_request_n,
        output register_select,
        output host_wdata,
        output host_wdata_oe,
        input  host_data_bus,
        input  ack_line_n
    );
endinterface

// File: src/cbp_dev.sv
// device end of the cpu bus register port: byte register file,
// read / write / interrupt-acknowledge sequencing on core_clk
// assumes master inputs are synchronous to core_clk
`timescale 1ns/1ps
`include "cbp_regs.svh"

module cbp_dev #(
    parameter int ADDR_W = `CBP_ADDR_W,
    parameter int DATA_W = `CBP_DATA_W
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rstn,
    // bus pins
    cbp_if.dev                     bus,
    // user side: vector offered in acknowledge cycles
    input  wire logic [DATA_W-1:0] vector_in,
    // user side: write notification
    output logic                   wr_pulse,
    output logic [ADDR_W-1:0]      wr_addr,
    output logic [DATA_W-1:0]      wr_data,
    // user side: one pulse per acknowledge cycle
    output logic                   int_ack_request_n_pulse
);

    // -----------------------------------------------------------------
    // storage and state
    // -----------------------------------------------------------------
    logic [DATA_W-1:0]       regs [0:(1<<ADDR_W)-1];
    cbp_pkg::cbp_dev_state_e state;
    cbp_pkg::cbp_cycle_e     cycle;
    logic                    sel_seen;
    logic                    int_ack_request_n_seen;
    logic [ADDR_W-1:0]       addr_q;
    logic                    cycle_over;
    logic                    rd_ok;
    logic                    wr_ok;
    logic                    ia_ok;

    // -----------------------------------------------------------------
    // falling-edge sampling of cycle starts
    // -----------------------------------------------------------------
    // falling edge sample
    // half a cycle of setup for the rising-edge sequencer
    always_ff @(negedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sel_seen  <= 1'b0;
            int_ack_request_n_seen <= 1'b0;
        end else begin
            sel_seen  <= ~bus.cs_n;
            int_ack_request_n_seen <= ~bus.int_ack_request_n;
        end
    end

    // -----------------------------------------------------------------
    // access qualifiers
    // -----------------------------------------------------------------
    // read qualifier
    assign rd_ok = sel_seen & ~bus.cs_n & ~bus.data_strobe_n & bus.rw;
    assign wr_ok = sel_seen & ~bus.cs_n & ~bus.data_strobe_n & ~bus.rw;
    assign ia_ok = int_ack_request_n_seen & ~bus.int_ack_request_n & ~bus.data_strobe_n;

    always_comb begin
        case (cycle)
            cbp_pkg::CBP_CYC_INT_ACK_REQUEST_N:  cycle_over = bus.int_ack_request_n | bus.data_strobe_n;
            cbp_pkg::CBP_CYC_WRITE: cycle_over = bus.data_strobe_n;
            default:                cycle_over = bus.cs_n | bus.data_strobe_n;
        endcase
    end

    // -----------------------------------------------------------------
    // sequencer
    // -----------------------------------------------------------------
    // clocked sequencing
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state  <= cbp_pkg::CBP_DEV_IDLE;
            cycle  <= cbp_pkg::CBP_CYC_READ;
            addr_q <= '0;
        end else begin
            case (state)
                cbp_pkg::CBP_DEV_IDLE: begin
                    if (ia_ok) begin
                        cycle <= cbp_pkg::CBP_CYC_INT_ACK_REQUEST_N;
                        state <= cbp_pkg::CBP_DEV_PRESENT;
                    end else if (rd_ok) begin
                        cycle  <= cbp_pkg::CBP_CYC_READ;
                        addr_q <= bus.register_select;
                        state  <= cbp_pkg::CBP_DEV_PRESENT;
                    end else if (wr_ok) begin
                        cycle  <= cbp_pkg::CBP_CYC_WRITE;
                        addr_q <= bus.register_select;
                        state  <= cbp_pkg::CBP_DEV_ACK;
                    end
                end
                cbp_pkg::CBP_DEV_PRESENT: begin
                    state <= cbp_pkg::CBP_DEV_ACK;
                end
                cbp_pkg::CBP_DEV_ACK: begin
                    if (cycle_over) begin
                        state <= cbp_pkg::CBP_DEV_DEASSERT;
                    end
                end
                cbp_pkg::CBP_DEV_DEASSERT: begin
                    state <= cbp_pkg::CBP_DEV_RELEASE;
                end
                cbp_pkg::CBP_DEV_RELEASE: begin
                    // no restart while the old cycle is still selected
                    if (!sel_seen && !int_ack_request_n_seen) begin
                        state <= cbp_pkg::CBP_DEV_IDLE;
                    end
                end
                default: begin
                    state <= cbp_pkg::CBP_DEV_IDLE;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // data bus drive
    // -----------------------------------------------------------------
    // float unless read or acknowledge
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bus.dev_rdata_oe <= 1'b0;
            bus.dev_rdata    <= `CBP_DATA_IDLE;
        end else begin
            if (state == cbp_pkg::CBP_DEV_IDLE && ia_ok) begin
                bus.dev_rdata_oe <= 1'b1;
                bus.dev_rdata    <= vector_in;
            end else if (state == cbp_pkg::CBP_DEV_IDLE && rd_ok) begin
                bus.dev_rdata_oe <= 1'b1;
                bus.dev_rdata    <= regs[bus.register_select];
            end else if (state == cbp_pkg::CBP_DEV_ACK && cycle_over) begin
                bus.dev_rdata_oe <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // transfer acknowledge
    // -----------------------------------------------------------------
    // asserted on clock edge
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bus.transfer_ack_n  <= `CBP_LINE_HIGH;
            bus.transfer_ack_oe <= 1'b0;
        end else begin
            case (state)
                cbp_pkg::CBP_DEV_IDLE: begin
                    if (!ia_ok && !rd_ok && wr_ok) begin
                        bus.transfer_ack_n  <= `CBP_LINE_LOW;
                        bus.transfer_ack_oe <= 1'b1;
                    end
                end
                cbp_pkg::CBP_DEV_PRESENT: begin
                    bus.transfer_ack_n  <= `CBP_LINE_LOW;
                    bus.transfer_ack_oe <= 1'b1;
                end
                cbp_pkg::CBP_DEV_ACK: begin
                    if (cycle_over) begin
                        bus.transfer_ack_n <= `CBP_LINE_HIGH;
                    end
                end
                cbp_pkg::CBP_DEV_DEASSERT: begin
                    bus.transfer_ack_oe <= 1'b0;
                end
                default: begin
                    bus.transfer_ack_n  <= `CBP_LINE_HIGH;
                    bus.transfer_ack_oe <= 1'b0;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // register file write
    // -----------------------------------------------------------------
    // capture at strobe negation
    always_ff @(posedge core_clk) begin
        if (state == cbp_pkg::CBP_DEV_ACK && cycle == cbp_pkg::CBP_CYC_WRITE
            && cycle_over) begin
            regs[addr_q] <= bus.host_data_bus;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_pulse <= 1'b0;
            wr_addr  <= '0;
            wr_data  <= `CBP_REG_RESET;
        end else begin
            wr_pulse <= 1'b0;
            if (state == cbp_pkg::CBP_DEV_ACK && cycle == cbp_pkg::CBP_CYC_WRITE
                && cycle_over) begin
                wr_pulse <= 1'b1;
                wr_addr  <= addr_q;
                wr_data  <= bus.host_data_bus;
            end
        end
    end

    // -----------------------------------------------------------------
    // acknowledge cycle notification
    // -----------------------------------------------------------------
    // one pulse per cycle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            int_ack_request_n_pulse <= 1'b0;
        end else begin
            int_ack_request_n_pulse <= (state == cbp_pkg::CBP_DEV_ACK)
                          && (cycle == cbp_pkg::CBP_CYC_INT_ACK_REQUEST_N) && cycle_over;
        end
    end

endmodule

// File: src/cbp_host.sv
// bus master end of the cpu bus register port
// assumes the device answers on the same core_clk
`timescale 1ns/1ps
`include "cbp_regs.svh"

module cbp_host #(
    parameter int ADDR_W = `CBP_ADDR_W,
    parameter int DATA_W = `CBP_DATA_W
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rstn,
    // bus pins
    cbp_if.host                    bus,
    // user request
    input  wire logic              req,
    input  wire logic [1:0]        req_kind,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    // user answer
    output logic                   busy,
    output logic                   done,
    output logic [DATA_W-1:0]      rdata
);

    cbp_pkg::cbp_hst_state_e state;
    cbp_pkg::cbp_cycle_e     kind;
    logic [1:0]              gap;

    // -----------------------------------------------------------------
    // master sequencer
    // -----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state                 <= cbp_pkg::CBP_HST_IDLE;
            kind                  <= cbp_pkg::CBP_CYC_READ;
            gap                   <= '0;
            busy                  <= 1'b0;
            done                  <= 1'b0;
            rdata                 <= `CBP_DATA_IDLE;
            bus.cs_n              <= `CBP_LINE_HIGH;
            bus.data_strobe_n     <= `CBP_LINE_HIGH;
            bus.int_ack_request_n <= `CBP_LINE_HIGH;
            bus.rw                <= `CBP_LINE_HIGH;
            bus.register_select   <= '0;
            bus.host_wdata        <= `CBP_DATA_IDLE;
            bus.host_wdata_oe     <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                cbp_pkg::CBP_HST_IDLE: begin
                    if (req) begin
                        kind  <= cbp_pkg::cbp_cycle_e'(req_kind);
                        busy  <= 1'b1;
                        bus.register_select <= req_addr;
                        bus.rw              <= (req_kind != 2'(cbp_pkg::CBP_CYC_WRITE));
                        bus.host_wdata      <= req_wdata;
                        bus.host_wdata_oe   <= (req_kind == 2'(cbp_pkg::CBP_CYC_WRITE));
                        state <= cbp_pkg::CBP_HST_SETUP;
                    end
                end
                cbp_pkg::CBP_HST_SETUP: begin
                    bus.data_strobe_n <= `CBP_LINE_LOW;
                    if (kind == cbp_pkg::CBP_CYC_INT_ACK_REQUEST_N) begin
                        bus.int_ack_request_n <= `CBP_LINE_LOW;
                    end else begin
                        bus.cs_n <= `CBP_LINE_LOW;
                    end
                    state <= cbp_pkg::CBP_HST_STROBE;
                end
                cbp_pkg::CBP_HST_STROBE: begin
                    if (!bus.ack_line_n) begin
                        rdata                 <= bus.host_data_bus;
                        bus.data_strobe_n     <= `CBP_LINE_HIGH;
                        bus.cs_n              <= `CBP_LINE_HIGH;
                        bus.int_ack_request_n <= `CBP_LINE_HIGH;
                        state                 <= cbp_pkg::CBP_HST_END;
                    end
                end
                cbp_pkg::CBP_HST_END: begin
                    // address and data held until released
                    if (bus.ack_line_n) begin
                        bus.host_wdata_oe <= 1'b0;
                        gap               <= `CBP_GAP_CLKS;
                        state             <= cbp_pkg::CBP_HST_GAP;
                    end
                end
                cbp_pkg::CBP_HST_GAP: begin
                    // select and request stay high for the least gap
                    if (gap == 2'h1) begin
                        busy  <= 1'b0;
                        done  <= 1'b1;
                        state <= cbp_pkg::CBP_HST_IDLE;
                    end
                    gap <= gap - 2'h1;
                end
                default: begin
                    state <= cbp_pkg::CBP_HST_IDLE;
                end
            endcase
        end
    end

endmodule

// File: tb/cbp_properties.sv
// concurrent checks on the lines between the two port ends
// assumes one core_clk for both ends; instantiated beside the interface
`timescale 1ns/1ps
`include "cbp_regs.svh"

module cbp_properties (
    // clock and reset
    input wire logic                   core_clk,
    input wire logic                   rstn,
    // master lines
    input wire logic                   cs_n,
    input wire logic                   data_strobe_n,
    input wire logic                   rw,
    input wire logic                   int_ack_request_n,
    input wire logic                   host_wdata_oe,
    // device lines
    input wire logic                   dev_rdata_oe,
    input wire logic                   transfer_ack_n,
    input wire logic                   transfer_ack_oe,
    // resolved lines
    input wire logic [`CBP_DATA_W-1:0] host_data_bus,
    input wire logic                   ack_line_n
);
    // ---------------------------------------------------------
    // handshake sequences
    // ---------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_ack_up;
        $rose(transfer_ack_n) && transfer_ack_oe;
    endsequence

    sequence s_ack_off;
        !transfer_ack_oe;
    endsequence

    sequence s_cycle_start;
        ($fell(cs_n) || $fell(int_ack_request_n)) && !data_strobe_n;
    endsequence

    // ---------------------------------------------------------
    // assertions
    // ---------------------------------------------------------
    a_ack_then_float: assert property (s_ack_up |=> s_ack_off)
        else $error("ack line not floated one clock after going high");
    a_ack_after_start: assert property (s_cycle_start |-> ##[1:3] !ack_line_n)
        else $error("no ack within three clocks of cycle start");
    a_ack_needs_strobe: assert property (!ack_line_n |-> !$past(data_strobe_n))
        else $error("ack low without data strobe");
    a_ack_withdrawn: assert property (!ack_line_n && data_strobe_n |=> ack_line_n)
        else $error("ack still low a clock after strobe high");
    a_read_data_first: assert property ($fell(ack_line_n) && rw |-> $past(dev_rdata_oe))
        else $error("read ack without data driven before");
    a_data_only_cycle: assert property (dev_rdata_oe |->
            (!$past(cs_n) && $past(rw)) || !$past(int_ack_request_n))
        else $error("data bus driven outside read or acknowledge");
    a_data_float_end: assert property (dev_rdata_oe && data_strobe_n |=> !dev_rdata_oe)
        else $error("data bus still driven after strobe high");
    a_no_drive_write: assert property (!rw && !cs_n |-> !dev_rdata_oe)
        else $error("device drives data during write");
    a_no_bus_fight: assert property (!(dev_rdata_oe && host_wdata_oe))
        else $error("both ends drive the data bus");
    a_read_data_stable: assert property (!ack_line_n && rw |-> $stable(host_data_bus))
        else $error("read data changed while ack low");
    a_reset_float: assert property (disable iff (1'b0)
            !rstn |-> !dev_rdata_oe && !transfer_ack_oe)
        else $error("device drives lines in reset");
endmodule

// File: tb/async_cpu_bus_register_port_tb_top.sv
// self-checking bench: master end and device end joined by one interface
// assumes 250 MHz core_clk; a second interface carries a misbehaving master
`timescale 1ns/1ps
`include "cbp_regs.svh"

module async_cpu_bus_register_port_tb_top;
    logic                               core_clk;
    logic                               rstn;
    logic                               req;
    logic [1:0]                         req_kind;
    logic [`CBP_ADDR_W-1:0]             req_addr;
    logic [`CBP_DATA_W-1:0]             req_wdata;
    logic [`CBP_DATA_W-1:0]             vector_in;
    logic                               busy;
    logic                               done;
    logic [`CBP_DATA_W-1:0]             rdata;
    logic                               wr_pulse;
    logic                               int_ack_request_n_pulse;
    logic [`CBP_ADDR_W-1:0]             wr_addr;
    logic [`CBP_DATA_W-1:0]             wr_data;
    logic [`CBP_DATA_W-1:0]             mem [`CBP_REG_COUNT];
    logic [1:0]                         q_kind [$];
    logic [`CBP_DATA_W-1:0]             q_val [$];
    logic [`CBP_ADDR_W+`CBP_DATA_W-1:0] q_wr [$];
    logic [1:0]                         mon_kind;
    logic [`CBP_DATA_W-1:0]             mon_val;
    logic [`CBP_ADDR_W-1:0]             a;
    logic [1:0]                         k;
    logic [`CBP_DATA_W-1:0]             v;
    int                                 q_ia;
    int                                 mismatches;
    int                                 compares;

    // ---------------------------------------------------------
    // clock, ends and checker
    // ---------------------------------------------------------
    always #2 core_clk = ~core_clk;

    cbp_if bus_if ();
    cbp_if bad_if ();

    cbp_host cbp_host_inst (.core_clk(core_clk), .rstn(rstn), .bus(bus_if), .req(req),
        .req_kind(req_kind), .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy),
        .done(done), .rdata(rdata));
    cbp_dev cbp_dev_inst (.core_clk(core_clk), .rstn(rstn), .bus(bus_if),
        .vector_in(vector_in), .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data),
        .int_ack_request_n_pulse(int_ack_request_n_pulse));
    // second device faces a bench-driven master that breaks the strobe gating
    cbp_dev cbp_dev_bad_inst (.core_clk(core_clk), .rstn(rstn), .bus(bad_if),
        .vector_in(vector_in), .wr_pulse(), .wr_addr(), .wr_data(), .int_ack_request_n_pulse());
    cbp_properties cbp_properties_inst (.core_clk(core_clk), .rstn(rstn),
        .cs_n(bus_if.cs_n), .data_strobe_n(bus_if.data_strobe_n), .rw(bus_if.rw),
        .int_ack_request_n(bus_if.int_ack_request_n), .host_wdata_oe(bus_if.host_wdata_oe),
        .dev_rdata_oe(bus_if.dev_rdata_oe), .transfer_ack_n(bus_if.transfer_ack_n),
        .transfer_ack_oe(bus_if.transfer_ack_oe), .host_data_bus(bus_if.host_data_bus),
        .ack_line_n(bus_if.ack_line_n));

    // ---------------------------------------------------------
    // compare tasks and verdict
    // ---------------------------------------------------------
    task automatic cmp_byte(input logic [`CBP_DATA_W-1:0] got, input logic [`CBP_DATA_W-1:0] e);
        compares++;
        if (got !== e) begin
            mismatches++;
            $display("ERROR %0t byte got %h expected %h", $time, got, e);
        end
    endtask

    task automatic cmp_write(input logic [`CBP_ADDR_W+`CBP_DATA_W-1:0] got,
                             input logic [`CBP_ADDR_W+`CBP_DATA_W-1:0] e);
        compares++;
        if (got !== e) begin
            mismatches++;
            $display("ERROR %0t write got %h expected %h", $time, got, e);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic e);
        compares++;
        if (got !== e) begin
            mismatches++;
            $display("ERROR %0t flag got %b expected %b", $time, got, e);
        end
    endtask

    task automatic conclude;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ---------------------------------------------------------
    // driver: one request, expectation noted first
    // ---------------------------------------------------------
    task automatic do_req(input logic [1:0] kind, input logic [`CBP_ADDR_W-1:0] addr,
                          input logic [`CBP_DATA_W-1:0] val);
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        q_kind.push_back(kind);
        q_val.push_back(val);
        if (kind == 2'h1)
            q_wr.push_back({addr, val});
        if (kind == 2'h2) begin
            vector_in = val;
            q_ia++;
        end
        req       = 1'b1;
        req_kind  = kind;
        req_addr  = addr;
        req_wdata = val;
        @(negedge core_clk);
        req = 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        cmp_byte(bus_if.host_data_bus, `CBP_DATA_IDLE);
        cmp_bit(bus_if.ack_line_n, 1'b1);
    endtask

    // ---------------------------------------------------------
    // monitor: oldest note against each result
    // ---------------------------------------------------------
    always @(negedge core_clk) begin
        if (rstn === 1'b1) begin
            if (done === 1'b1) begin
                mon_kind = q_kind.pop_front();
                mon_val  = q_val.pop_front();
                if (mon_kind != 2'h1)
                    cmp_byte(rdata, mon_val);
            end
            if (wr_pulse === 1'b1)
                cmp_write({wr_addr, wr_data}, q_wr.pop_front());
            if (int_ack_request_n_pulse === 1'b1) begin
                cmp_bit(q_ia > 0, 1'b1);
                q_ia--;
            end
        end
    end

    // ---------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------
    initial begin
        core_clk   = 1'b0;
        rstn       = 1'b1;
        req        = 1'b0;
        req_kind   = 2'h0;
        req_addr   = 5'h00;
        req_wdata  = 8'h00;
        vector_in  = 8'h00;
        mismatches = 0;
        compares   = 0;
        q_ia       = 0;
        bad_if.cs_n              = 1'b1;
        bad_if.data_strobe_n     = 1'b1;
        bad_if.rw                = 1'b1;
        bad_if.int_ack_request_n = 1'b1;
        bad_if.register_select   = 5'h00;
        bad_if.host_wdata        = 8'h00;
        bad_if.host_wdata_oe     = 1'b0;
        void'($urandom(32'h92C0443B));
        // clean falling reset edge before the first rising clock edge
        #1 rstn = 1'b0;
        repeat (5) @(negedge core_clk);
        cmp_bit(bus_if.dev_rdata_oe | bus_if.transfer_ack_oe, 1'b0);
        rstn = 1'b1;
        // every address written, then read back in reverse order
        for (int i = 0; i < `CBP_REG_COUNT; i++) begin
            mem[i] = 8'($urandom);
            do_req(2'h1, i[4:0], mem[i]);
        end
        for (int i = `CBP_REG_COUNT - 1; i >= 0; i--)
            do_req(2'h0, i[4:0], mem[i]);
        // mixed back-to-back traffic, acknowledge cycles included
        repeat (40) begin
            a = 5'($urandom);
            k = 2'($urandom_range(2));
            v = 8'($urandom);
            if (k == 2'h1)
                mem[a] = v;
            do_req(k, a, (k == 2'h0) ? mem[a] : v);
        end
        // select without strobe must not start a cycle
        @(negedge core_clk);
        bad_if.cs_n = 1'b0;
        repeat (6) begin
            @(negedge core_clk);
            cmp_bit(bad_if.ack_line_n, 1'b1);
            cmp_byte(bad_if.host_data_bus, `CBP_DATA_IDLE);
        end
        bad_if.cs_n = 1'b1;
        // reset in mid-run, then traffic resumes
        rstn = 1'b0;
        @(negedge core_clk);
        cmp_bit(bus_if.dev_rdata_oe | bus_if.transfer_ack_oe, 1'b0);
        rstn = 1'b1;
        do_req(2'h1, 5'h1F, 8'hA5);
        do_req(2'h0, 5'h1F, 8'hA5);
        repeat (4) @(negedge core_clk);
        cmp_bit(q_wr.size() == 0 && q_kind.size() == 0 && q_ia == 0, 1'b1);
        conclude();
    end

    // watchdog: run needs about 930 clocks
    initial begin
        repeat (6000) @(posedge core_clk);
        mismatches++;
        conclude();
    end
endmodule
